// [logic/sfp_flash_port.v]
// Serial flash target port: SPI slave, byte array, erase engine, APB regs.
// Assumes SPI pins are asynchronous to pclk and sck is well below pclk/4.
`timescale 1ns/1ps
`include "sfp_regs.vh"
module sfp_flash_port #(
  parameter AW          = 20,             // byte address bits
  parameter PROG_CYCLES = `SFP_PROG_CYC   // byte program busy cycles
) (
  input  wire        pclk,      // bus clock, 40 MHz
  input  wire        presetn,   // async reset, active low
  input  wire        psel,      // APB select
  input  wire        penable,   // APB enable
  input  wire        pwrite,    // APB direction
  input  wire [7:0]  paddr,     // APB byte address
  input  wire [31:0] pwdata,    // APB write data
  output reg  [31:0] prdata,    // APB read data
  output reg         pready,    // APB ready
  output reg         pslverr,   // APB error, unmapped address
  output reg         irq,       // interrupt level, active high
  input  wire        sck,       // serial clock from host
  input  wire        cs_n,      // select, active low
  input  wire        si,        // serial data in
  output reg         so_o,      // serial data out
  output reg         so_oe,     // serial out enable
  input  wire        hold_n,    // pause, active low
  input  wire        wp_n       // write guard, active low
);
  localparam PH_IDLE = 3'd0;
  localparam PH_CMD  = 3'd1;
  localparam PH_ADDR = 3'd2;
  localparam PH_DIN  = 3'd3;
  localparam PH_WSR  = 3'd4;
  localparam PH_READ = 3'd5;
  localparam PH_STAT = 3'd6;
  localparam [15:0] PROG_LOAD = PROG_CYCLES[15:0];

  // Array contents are not reset; erase before reading a region
  reg [7:0] mem [0:(1<<AW)-1];

  function prot_hit;
    input [3:0] top;
    input [2:0] bp;
    begin
      case (bp)
        3'd0:    prot_hit = 1'b0;
        3'd1:    prot_hit = (top == 4'hF);
        3'd2:    prot_hit = (top[3:1] == 3'h7);
        3'd3:    prot_hit = (top[3:2] == 2'h3);
        3'd4:    prot_hit = top[3];
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  function [AW-1:0] er_mask;
    input [7:0] op;
    begin
      case (op)
        `SFP_OP_ER4K:  er_mask = {{(AW-`SFP_SECT_BITS){1'b0}}, {`SFP_SECT_BITS{1'b1}}};
        `SFP_OP_ER32K: er_mask = {{(AW-`SFP_BLK32_BITS){1'b0}}, {`SFP_BLK32_BITS{1'b1}}};
        default:       er_mask = {{(AW-`SFP_BLK64_BITS){1'b0}}, {`SFP_BLK64_BITS{1'b1}}};
      endcase
    end
  endfunction

  // Pin synchronisers: order is sck, cs_n, si, hold_n, wp_n
  wire [4:0] pin_s;
  // Reset to idle pin levels so no false sck edge follows reset
  sfp_sync #(.W(5), .RST(5'h0B)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({sck, cs_n, si, hold_n, wp_n}),
    .q     (pin_s)
  );
  wire sck_s    = pin_s[4];
  wire cs_n_s   = pin_s[3];
  wire si_s     = pin_s[2];
  wire hold_n_s = pin_s[1];
  wire wp_n_s   = pin_s[0];

  reg          sck_prev_reg;
  reg          cs_prev_reg;
  reg          active_reg;
  reg          hold_reg;
  reg [2:0]    phase_reg;
  reg [2:0]    bit_cnt_reg;
  reg [6:0]    in_sh_reg;
  reg [7:0]    out_sh_reg;
  reg [7:0]    cmd_reg;
  reg [23:0]   addr_reg;
  reg [1:0]    acnt_reg;
  reg          wel_reg;
  reg          aai_reg;
  reg [3:0]    bp_reg;
  reg          bpl_reg;
  reg          rb_en_reg;
  reg [15:0]   prog_cnt_reg;
  reg          prog_we_reg;
  reg [AW-1:0] prog_addr_reg;
  reg [7:0]    prog_data_reg;
  reg          er_run_reg;
  reg [AW-1:0] er_addr_reg;
  reg [AW-1:0] er_last_reg;
  reg          busy_prev_reg;
  reg [`SFP_EV_W-1:0] ev_reg;

  wire busy     = (prog_cnt_reg != 16'h0000) | er_run_reg;
  wire [7:0] status = {bpl_reg, aai_reg, bp_reg, wel_reg, busy};
  wire cs_fall  = cs_prev_reg & ~cs_n_s;
  wire run      = active_reg & ~hold_reg & ~cs_n_s;
  wire sck_rise = run & sck_s & ~sck_prev_reg;
  wire sck_fall = run & ~sck_s & sck_prev_reg;
  wire rx_done  = sck_rise & (bit_cnt_reg == 3'd7);
  wire [7:0] rx_byte = {in_sh_reg, si_s};
  wire [23:0] addr_full = {addr_reg[15:0], rx_byte};
  wire [23:0] addr_inc  = addr_reg + 24'h000001;
  wire [AW-1:0] rd_idx  = (phase_reg == PH_ADDR) ? addr_full[AW-1:0] : addr_inc[AW-1:0];
  wire [7:0] rd_data    = mem[rd_idx];
  wire [AW-1:0] er_base = addr_full[AW-1:0] & ~er_mask(cmd_reg);
  wire [AW-1:0] er_end  = er_base | er_mask(cmd_reg);
  wire er_prot   = prot_hit(er_end[AW-1:AW-4], bp_reg[2:0]);
  wire wr_prot   = prot_hit(addr_reg[AW-1:AW-4], bp_reg[2:0]);
  wire wsr_ok    = wp_n_s | ~bpl_reg;
  wire out_phase = (phase_reg == PH_READ) | (phase_reg == PH_STAT);
  wire rb_mode   = aai_reg & rb_en_reg & ~out_phase;
  wire aai_top   = (addr_reg[AW-1:0] == {AW{1'b1}});

  // Serial interface and device state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_reg  <= 1'b0;
      cs_prev_reg   <= 1'b1;
      active_reg    <= 1'b0;
      hold_reg      <= 1'b0;
      phase_reg     <= PH_IDLE;
      bit_cnt_reg   <= 3'd0;
      in_sh_reg     <= 7'h00;
      out_sh_reg    <= 8'h00;
      cmd_reg       <= 8'h00;
      addr_reg      <= 24'h000000;
      acnt_reg      <= 2'd0;
      wel_reg       <= 1'b0;
      aai_reg       <= 1'b0;
      bp_reg        <= `SFP_BP_RST;
      bpl_reg       <= `SFP_BPL_RST;
      prog_cnt_reg  <= 16'h0000;
      prog_we_reg   <= 1'b0;
      prog_addr_reg <= {AW{1'b0}};
      prog_data_reg <= 8'h00;
      er_run_reg    <= 1'b0;
      er_addr_reg   <= {AW{1'b0}};
      er_last_reg   <= {AW{1'b0}};
      busy_prev_reg <= 1'b0;
      ev_reg        <= {`SFP_EV_W{1'b0}};
      so_o          <= 1'b0;
      so_oe         <= 1'b0;
    end else begin
      sck_prev_reg  <= sck_s;
      cs_prev_reg   <= cs_n_s;
      busy_prev_reg <= busy;
      prog_we_reg   <= 1'b0;
      ev_reg        <= {`SFP_EV_W{1'b0}};
      ev_reg[`SFP_EV_DONE] <= busy_prev_reg & ~busy;
      if (prog_cnt_reg != 16'h0000) begin
        prog_cnt_reg <= prog_cnt_reg - 16'h0001;
      end
      if (er_run_reg) begin
        er_addr_reg <= er_addr_reg + {{(AW-1){1'b0}}, 1'b1};
        er_run_reg  <= (er_addr_reg != er_last_reg);
      end
      if (cs_n_s) begin
        // Deselect drops any partial command
        active_reg <= 1'b0;
        hold_reg   <= 1'b0;
        phase_reg  <= PH_IDLE;
        ev_reg[`SFP_EV_HOLD_RST] <= hold_reg;
      end else if (cs_fall) begin
        active_reg  <= 1'b1;
        phase_reg   <= PH_CMD;
        bit_cnt_reg <= 3'd0;
      end else if (active_reg && !sck_s) begin
        // Pause edges take effect only in the low phase of sck
        hold_reg <= ~hold_n_s;
      end
      if (sck_fall && out_phase) begin
        so_o       <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end else if (rb_mode) begin
        so_o <= ~busy;
      end
      so_oe <= run & (out_phase | rb_mode);
      if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        in_sh_reg   <= rx_byte[6:0];
      end
      if (rx_done) begin
        case (phase_reg)
          PH_CMD: begin
            cmd_reg  <= rx_byte;
            acnt_reg <= 2'd0;
            phase_reg <= PH_IDLE;
            case (rx_byte)
              `SFP_OP_READ: begin
                if (!busy) phase_reg <= PH_ADDR;
              end
              `SFP_OP_PROG, `SFP_OP_ER4K, `SFP_OP_ER32K, `SFP_OP_ER64K: begin
                if (!busy && wel_reg && !aai_reg) phase_reg <= PH_ADDR;
              end
              `SFP_OP_AAI: begin
                if (!busy && aai_reg) phase_reg <= PH_DIN;
                else if (!busy && wel_reg) phase_reg <= PH_ADDR;
              end
              `SFP_OP_RDSR: begin
                phase_reg  <= PH_STAT;
                out_sh_reg <= status;
              end
              `SFP_OP_WREN: begin
                if (!busy) wel_reg <= 1'b1;
              end
              `SFP_OP_WRDI: begin
                if (!busy) begin
                  wel_reg <= 1'b0;
                  aai_reg <= 1'b0;
                end
              end
              `SFP_OP_STATUS_WRITE_CMD: begin
                if (!busy && wel_reg && !aai_reg) phase_reg <= PH_WSR;
              end
              default: phase_reg <= PH_IDLE;
            endcase
          end
          PH_ADDR: begin
            addr_reg <= addr_full;
            acnt_reg <= acnt_reg + 2'd1;
            if (acnt_reg == 2'd2) begin
              case (cmd_reg)
                `SFP_OP_READ: begin
                  phase_reg  <= PH_READ;
                  out_sh_reg <= rd_data;
                end
                `SFP_OP_PROG, `SFP_OP_AAI: phase_reg <= PH_DIN;
                default: begin
                  // Whole region must be unprotected, else refuse
                  phase_reg <= PH_IDLE;
                  wel_reg   <= 1'b0;
                  if (er_prot) begin
                    ev_reg[`SFP_EV_PROT_REF] <= 1'b1;
                  end else begin
                    er_run_reg  <= 1'b1;
                    er_addr_reg <= er_base;
                    er_last_reg <= er_end;
                  end
                end
              endcase
            end
          end
          PH_DIN: begin
            phase_reg <= PH_IDLE;
            if (wr_prot) begin
              ev_reg[`SFP_EV_PROT_REF] <= 1'b1;
              wel_reg <= 1'b0;
              aai_reg <= 1'b0;
            end else begin
              prog_we_reg   <= 1'b1;
              prog_addr_reg <= addr_reg[AW-1:0];
              prog_data_reg <= rx_byte;
              prog_cnt_reg  <= PROG_LOAD;
              if (cmd_reg == `SFP_OP_AAI) begin
                addr_reg <= addr_inc;
                aai_reg  <= ~aai_top;
                wel_reg  <= ~aai_top;
              end else begin
                wel_reg <= 1'b0;
              end
            end
          end
          PH_WSR: begin
            phase_reg <= PH_IDLE;
            wel_reg   <= 1'b0;
            if (wsr_ok) begin
              bp_reg  <= rx_byte[`SFP_ST_BP_LO+3:`SFP_ST_BP_LO];
              bpl_reg <= rx_byte[`SFP_ST_BPL];
            end else begin
              ev_reg[`SFP_EV_WSR_REF] <= 1'b1;
            end
          end
          PH_READ: begin
            addr_reg   <= addr_inc;
            out_sh_reg <= rd_data;
          end
          PH_STAT: begin
            out_sh_reg <= status;
          end
          default: phase_reg <= PH_IDLE;
        endcase
      end
    end
  end

  // Array write port: erase fills with ones, program stores a byte
  always @(posedge pclk) begin
    if (er_run_reg) begin
      mem[er_addr_reg] <= 8'hFF;
    end else if (prog_we_reg) begin
      mem[prog_addr_reg] <= prog_data_reg;
    end
  end

  // APB slave, zero wait states
  wire setup    = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire [`SFP_EV_W-1:0] int_stat;
  wire [`SFP_EV_W-1:0] int_en;
  wire irq_int;

  sfp_irq #(.W(`SFP_EV_W)) u_irq (
    .clk    (pclk),
    .rst_n  (presetn),
    .ev     (ev_reg),
    .clr_we (wr_acc & (paddr == `SFP_OFF_INT_CLR)),
    .en_we  (wr_acc & (paddr == `SFP_OFF_INT_EN)),
    .wdata  (pwdata[`SFP_EV_W-1:0]),
    .stat   (int_stat),
    .en     (int_en),
    .irq    (irq_int)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      rb_en_reg <= `SFP_CTRL_RST;
      irq       <= 1'b0;
    end else begin
      pready <= 1'b1;
      irq    <= irq_int;
      if (wr_acc && paddr == `SFP_OFF_CTRL) begin
        rb_en_reg <= pwdata[`SFP_CTRL_RB_EN];
      end
      if (setup) begin
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
        case (paddr)
          `SFP_OFF_STATUS:   prdata <= {22'h00000, active_reg, hold_reg, status};
          `SFP_OFF_CTRL:     prdata <= {31'h0000000, rb_en_reg};
          `SFP_OFF_INT_STAT: prdata <= {{(32-`SFP_EV_W){1'b0}}, int_stat};
          `SFP_OFF_INT_CLR:  prdata <= 32'h00000000;
          `SFP_OFF_INT_EN:   prdata <= {{(32-`SFP_EV_W){1'b0}}, int_en};
          default:           pslverr <= 1'b1;
        endcase
        // Write accesses always return zero data
        if (pwrite) begin
          prdata <= 32'h00000000;
        end
      end
    end
  end
endmodule

// [logic/sfp_regs.vh]
// Constants of the serial flash target port: APB map, opcodes, status layout.
// Included by the flash port and the testbench; definitions only.
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// APB register offsets (byte addresses)
`define SFP_OFF_STATUS   8'h00
`define SFP_OFF_CTRL     8'h04
`define SFP_OFF_INT_STAT 8'h08
`define SFP_OFF_INT_CLR  8'h0C
`define SFP_OFF_INT_EN   8'h10

// Control register fields
`define SFP_CTRL_RB_EN   0
`define SFP_CTRL_RST     1'h0

// Interrupt event bits
`define SFP_EV_W         4
`define SFP_EV_DONE      0
`define SFP_EV_WSR_REF   1
`define SFP_EV_HOLD_RST  2
`define SFP_EV_PROT_REF  3

// Serial opcodes
`define SFP_OP_READ      8'h03
`define SFP_OP_PROG      8'h02
`define SFP_OP_AAI       8'hAD
`define SFP_OP_ER4K      8'h20
`define SFP_OP_ER32K     8'h52
`define SFP_OP_ER64K     8'hD8
`define SFP_OP_RDSR      8'h05
`define SFP_OP_STATUS_WRITE_CMD      8'h01
`define SFP_OP_WREN      8'h06
`define SFP_OP_WRDI      8'h04

// Device status byte positions and reset values
`define SFP_ST_BUSY      0
`define SFP_ST_WEL       1
`define SFP_ST_BP_LO     2
`define SFP_ST_AAI       6
`define SFP_ST_BPL       7
`define SFP_BP_RST       4'h7
`define SFP_BPL_RST      1'h0

// Erase region sizes as address bits
`define SFP_SECT_BITS    12
`define SFP_BLK32_BITS   15
`define SFP_BLK64_BITS   16

// Byte program busy time in pclk cycles
`define SFP_PROG_CYC     16

`endif

// [logic/sfp_sync.v]
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level relative to pclk.
`timescale 1ns/1ps
module sfp_sync #(
  parameter W   = 1,
  parameter RST = 0
) (
  input  wire         clk,     // sampling clock
  input  wire         rst_n,   // async reset, active low
  input  wire [W-1:0] d,       // asynchronous inputs
  output reg  [W-1:0] q        // synchronised outputs
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST[W-1:0];
      q        <= RST[W-1:0];
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// [logic/sfp_irq.v]
// Sticky interrupt status, write-one-to-clear register and enable mask.
// Assumes one-cycle event pulses and write strobes from the same clock.
`timescale 1ns/1ps
module sfp_irq #(
  parameter W = 4
) (
  input  wire         clk,     // bus clock
  input  wire         rst_n,   // async reset, active low
  input  wire [W-1:0] ev,      // event pulses
  input  wire         clr_we,  // write strobe, clear register
  input  wire         en_we,   // write strobe, enable register
  input  wire [W-1:0] wdata,   // write data
  output reg  [W-1:0] stat,    // sticky status
  output reg  [W-1:0] en,      // enable mask
  output reg          irq      // level interrupt
);
  wire [W-1:0] clr = clr_we ? wdata : {W{1'b0}};
  // Set wins over a clear in the same cycle
  wire [W-1:0] stat_next = (stat & ~clr) | ev;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= {W{1'b0}};
      en   <= {W{1'b0}};
      irq  <= 1'b0;
    end else begin
      stat <= stat_next;
      if (en_we) begin
        en <= wdata;
      end
      irq <= |(stat_next & (en_we ? wdata : en));
    end
  end
endmodule

// [dv/sfp_port_asserts.sv]
// Port-level checker for the serial flash target port.
// Sees only the top module's ports; attached by the bind below.
`timescale 1ns/1ps
module sfp_port_chk (
  input wire        pclk,    // bus clock
  input wire        presetn, // async reset, active low
  input wire        psel,    // apb select
  input wire        penable, // apb enable
  input wire        pwrite,  // apb direction
  input wire [7:0]  paddr,   // apb address
  input wire [31:0] prdata,  // apb read data
  input wire        pready,  // apb ready
  input wire        pslverr, // apb error
  input wire        irq,     // interrupt level
  input wire        cs_n,    // select, active low
  input wire        sck,     // link clock
  input wire        hold_n,  // pause, active low
  input wire        so_oe    // serial out enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_desel_so_off: assert property (cs_n [*5] |-> !so_oe)
    else $error("serial out driven while deselected");
  a_pause_so_off: assert property ((!hold_n && !sck && !cs_n) [*6] |-> !so_oe)
    else $error("serial out driven while paused");
  a_drive_needs_sel: assert property ($rose(so_oe) |-> $past(!cs_n, 2))
    else $error("serial out enabled without select");
  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access not answered at once");
  a_apb_unmapped_err: assert property (psel && penable && (paddr > 8'h10 ||
    paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_apb_mapped_ok: assert property (psel && penable && paddr <= 8'h10 &&
    paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_write_reads_zero: assert property (psel && penable && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  a_reset_irq_ready: assert property (!$past(presetn) |-> !irq ##1 pready)
    else $error("irq or ready wrong after reset");
endmodule
bind sfp_flash_port sfp_port_chk i_sfp_port_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .cs_n(cs_n), .sck(sck),
  .hold_n(hold_n), .so_oe(so_oe));

// [dv/sfp_host_model.sv]
// Host-side master model driving the serial pins of the flash port.
// Assumes 25 ns pclk; link clock half period of 4 pclk (200 ns period).
`timescale 1ns/1ps
module sfp_host_model (
  input wire pclk,   // pacing clock
  input wire so_o,   // serial out from device
  input wire so_oe,  // device drives serial out
  output reg sck,    // link clock
  output reg cs_n,   // select, active low
  output reg si,     // serial data in
  output reg hold_n  // pause, active low
);
  reg  cpol    = 1'b0;
  reg  so_last = 1'b0;
  // Released line shows no stale value
  wire so_pin  = so_oe ? so_o : ~so_last;
  always @(posedge pclk) if (so_oe) so_last <= so_o;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task half;
    repeat (4) @(posedge pclk);
  endtask
  task start(input m);
    begin
      cpol = m;
      sck <= m;
      half;
      cs_n <= 1'b0;
      half;
      sck <= 1'b0;
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si <= tx[i];
        half;
        sck <= 1'b1;
        half;
        rx[i] = so_pin;
        sck <= 1'b0;
      end
    end
  endtask
  task stop;
    begin
      half;
      sck <= cpol;
      half;
      cs_n <= 1'b1;
      half;
      half;
    end
  endtask
endmodule

// [dv/tb_sfp_flash_port.sv]
// Self-checking bench: APB register tasks and host model frames.
// Assumes the flash port's default address width and program time.
`timescale 1ns/1ps
`include "sfp_regs.vh"
`define SFP_CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_sfp_flash_port;
  reg         pclk, presetn, psel, penable, pwrite, wp_n, last_err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, r;
  reg  [7:0]  b;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, sck, cs_n, si, so_o, so_oe, hold_n;
  integer     mismatches = 0, check_count = 0;
  sfp_flash_port i_sfp_flash_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sck(sck), .cs_n(cs_n), .si(si),
    .so_o(so_o), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n));
  sfp_host_model i_sfp_host_model (.pclk(pclk), .so_o(so_o), .so_oe(so_oe), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n));
  task apb(input wr, input [7:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      t = 0;
      while (pready !== 1'b1 && t < 50) begin
        @(posedge pclk);
        t = t + 1;
      end
      if (t == 50) mismatches = mismatches + 1;
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task frame(input [39:0] c, input integer n, input m);
    integer k;
    begin
      i_sfp_host_model.start(m);
      for (k = n - 1; k >= 0; k = k - 1) i_sfp_host_model.xfer(c[8*k+:8], b);
      i_sfp_host_model.stop;
    end
  endtask
  task wait_idle;
    integer t;
    begin
      t = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && t < 3000) begin
        apb(1'b0, `SFP_OFF_STATUS, 32'h0);
        t = t + 1;
      end
      `SFP_CHK(r[0], 1'b0)
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, `SFP_OFF_STATUS, 32'h0);
      `SFP_CHK(r, 32'h0000001C)
      apb(1'b0, 8'h20, 32'h0);
      `SFP_CHK(last_err, 1'b1)
      apb(1'b1, `SFP_OFF_CTRL, 32'h1);
      apb(1'b0, `SFP_OFF_CTRL, 32'h0);
      `SFP_CHK(r, 32'h00000001)
      apb(1'b1, `SFP_OFF_INT_EN, 32'hF);
    end
  endtask
  task t_spi_modes;
    integer m;
    for (m = 0; m < 2; m = m + 1) begin
      frame({`SFP_OP_RDSR, 8'h00}, 2, m[0]);
      `SFP_CHK(b, 8'h1C)
      i_sfp_host_model.start(m[0]);
      i_sfp_host_model.xfer(`SFP_OP_READ, b);
      i_sfp_host_model.stop;
      frame({`SFP_OP_RDSR, 8'h00}, 2, m[0]);
      `SFP_CHK(b, 8'h1C)
    end
  endtask
  task t_hold;
    begin
      i_sfp_host_model.start(1'b0);
      i_sfp_host_model.xfer(`SFP_OP_RDSR, b);
      i_sfp_host_model.hold_n <= 1'b0;
      repeat (12) @(posedge pclk);
      `SFP_CHK(so_oe, 1'b0)
      i_sfp_host_model.hold_n <= 1'b1;
      repeat (8) @(posedge pclk);
      i_sfp_host_model.xfer(8'h00, b);
      `SFP_CHK(b, 8'h1C)
      i_sfp_host_model.hold_n <= 1'b0;
      repeat (8) @(posedge pclk);
      i_sfp_host_model.cs_n <= 1'b1;
      repeat (8) @(posedge pclk);
      i_sfp_host_model.hold_n <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1'b0, `SFP_OFF_INT_STAT, 32'h0);
      `SFP_CHK(r[2], 1'b1)
      frame({`SFP_OP_RDSR, 8'h00}, 2, 1'b0);
      `SFP_CHK(b, 8'h1C)
    end
  endtask
  task t_protect;
    begin
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({`SFP_OP_PROG, 24'h012345, 8'h5A}, 5, 1'b0);
      apb(1'b0, `SFP_OFF_INT_STAT, 32'h0);
      `SFP_CHK(r[3], 1'b1)
      @(posedge pclk);
      `SFP_CHK(irq, 1'b1)
      apb(1'b1, `SFP_OFF_INT_CLR, 32'hF);
      repeat (3) @(posedge pclk);
      `SFP_CHK(irq, 1'b0)
    end
  endtask
  task t_status_write_cmd;
    begin
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({24'h0, `SFP_OP_STATUS_WRITE_CMD, 8'h80}, 2, 1'b0);
      frame({`SFP_OP_RDSR, 8'h00}, 2, 1'b0);
      `SFP_CHK(b, 8'h80)
      wp_n <= 1'b0;
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({24'h0, `SFP_OP_STATUS_WRITE_CMD, 8'h00}, 2, 1'b0);
      apb(1'b0, `SFP_OFF_INT_STAT, 32'h0);
      `SFP_CHK(r[1], 1'b1)
      apb(1'b0, `SFP_OFF_STATUS, 32'h0);
      `SFP_CHK(r[7:0], 8'h80)
      wp_n <= 1'b1;
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({24'h0, `SFP_OP_STATUS_WRITE_CMD, 8'h00}, 2, 1'b0);
      apb(1'b0, `SFP_OFF_STATUS, 32'h0);
      `SFP_CHK(r[7:0], 8'h00)
    end
  endtask
  task t_prog_erase;
    begin
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({`SFP_OP_PROG, 24'h012345, 8'h5A}, 5, 1'b0);
      wait_idle;
      frame({`SFP_OP_READ, 24'hF12345, 8'h00}, 5, 1'b1);
      `SFP_CHK(b, 8'h5A)
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({8'h0, `SFP_OP_ER4K, 24'h012FFF}, 4, 1'b0);
      apb(1'b0, `SFP_OFF_STATUS, 32'h0);
      `SFP_CHK(r[0], 1'b1)
      wait_idle;
      frame({`SFP_OP_READ, 24'h012345, 8'h00}, 5, 1'b0);
      `SFP_CHK(b, 8'hFF)
      apb(1'b0, `SFP_OFF_INT_STAT, 32'h0);
      `SFP_CHK(r[0], 1'b1)
      frame({32'h0, `SFP_OP_WREN}, 1, 1'b0);
      frame({`SFP_OP_AAI, 24'h001000, 8'h11}, 5, 1'b0);
      wait_idle;
      i_sfp_host_model.start(1'b0);
      repeat (8) @(posedge pclk);
      `SFP_CHK({so_oe, so_o}, 2'b11)
      i_sfp_host_model.xfer(`SFP_OP_WRDI, b);
      i_sfp_host_model.stop;
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #(25 * 80000);
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    wp_n = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    t_regs;
    t_spi_modes;
    t_hold;
    t_protect;
    t_status_write_cmd;
    t_prog_erase;
    end_of_test;
  end
endmodule
